// [rtl/napc_codec.sv]
// napc_codec: payload decoder for the navigation aiding packet group
// assumes a frame layer upstream that has checked header and checksum and gives the id and payload length
// What this block does
// - id 46 carries 24 bytes, six floats: north, east, down velocity then their standard deviations.
// - id 47 carries 16 bytes: body X, Y, Z velocity and one shared standard deviation.
// - id 48 carries 8 bytes: heading at byte 0, its standard deviation at byte 4.
// - id 49 carries 8 bytes: running seconds at byte 0, microseconds at byte 4.
// - id 50 carries 12 bytes: magnetic field X, Y, Z in milligauss.
// - id 52 carries 8 bytes: epoch seconds then microseconds.
// - id 53 carries 8 bytes: depth at byte 0, its standard deviation at byte 4.
// - id 54 carries 4 bytes: one float geoid height.
// - id 55 carries up to 255 bytes that pass unaltered to the satellite receiver.
`timescale 1ns/1ps
module napc_codec
    import napc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] pkt_id,
    input wire logic [8:0] pkt_len,
    input wire napc_byte_t pay_in,
    input wire logic [6:0] rd_addr,
    output logic [31:0] rd_data,
    output napc_field_t field_out,
    output napc_byte_t corr_out,
    output logic pkt_done,
    output logic pkt_reject,
    output logic [7:0] done_id
);
    function automatic logic [8:0] fixed_len(input logic [7:0] id);
        unique case (id)
            NAPC_ID_EXT_VEL: fixed_len = NAPC_LEN_EXT_VEL;
            NAPC_ID_BODY_VEL: fixed_len = NAPC_LEN_BODY_VEL;
            NAPC_ID_HEADING: fixed_len = NAPC_LEN_HEADING;
            NAPC_ID_RUN_TIME: fixed_len = NAPC_LEN_RUN_TIME;
            NAPC_ID_MAG_FIELD: fixed_len = NAPC_LEN_MAG_FIELD;
            NAPC_ID_EXT_TIME: fixed_len = NAPC_LEN_EXT_TIME;
            NAPC_ID_DEPTH: fixed_len = NAPC_LEN_DEPTH;
            NAPC_ID_GEOID: fixed_len = NAPC_LEN_GEOID;
            NAPC_ID_HEAVE: fixed_len = NAPC_LEN_HEAVE;
            default: fixed_len = 9'h000;
        endcase
    endfunction : fixed_len

    function automatic napc_kind_t kind_of(input logic [7:0] id);
        if (id == NAPC_ID_CORR) begin
            kind_of = NAPC_PKT_VARIABLE;
        end else if (fixed_len(id) != 9'h000) begin
            kind_of = NAPC_PKT_FIXED;
        end else begin
            kind_of = NAPC_PKT_UNKNOWN;
        end
    endfunction : kind_of

    // map id and word index onto a store slot: eight slots per id
    function automatic logic [6:0] slot_of(input logic [7:0] id, input logic [2:0] idx);
        slot_of = {id[3:0], idx};
    endfunction : slot_of

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FIXED,
        ST_PASS,
        ST_DROP
    } napc_state_t;

    napc_state_t state_reg;
    napc_state_t state_next;
    logic [7:0] id_reg;
    logic [1:0] byte_reg;
    logic [2:0] word_reg;
    logic [23:0] shift_reg;
    logic [31:0] word_now;
    logic word_full;
    logic [31:0] stage_reg [0:NAPC_MAX_WORDS-1];
    logic commit_reg;
    logic [2:0] commit_cnt_reg;
    logic [2:0] commit_idx_reg;
    logic wr_en;
    logic start_ok;
    logic [8:0] byte_count_reg;

    // length check up front: a packet with a bad declared length never reaches the staging words
    assign start_ok = (kind_of(pkt_id) == NAPC_PKT_FIXED && pkt_len == fixed_len(pkt_id))
        || (kind_of(pkt_id) == NAPC_PKT_VARIABLE && pkt_len <= NAPC_LEN_CORR_MAX);

    // little-endian: first byte is the least significant
    assign word_now = {pay_in.data, shift_reg};
    assign word_full = pay_in.valid && byte_reg == 2'h3;

    always_comb begin
        state_next = state_reg;
        if (pay_in.valid && pay_in.first) begin
            if (!start_ok) begin
                state_next = ST_DROP;
            end else if (kind_of(pkt_id) == NAPC_PKT_VARIABLE) begin
                state_next = ST_PASS;
            end else begin
                state_next = ST_FIXED;
            end
        end
        if (pay_in.valid && pay_in.last) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            id_reg <= 8'h00;
            byte_reg <= 2'h0;
            word_reg <= NAPC_WORD_RESET;
            shift_reg <= 24'h00_0000;
            byte_count_reg <= 9'h000;
        end else if (pay_in.valid) begin
            if (pay_in.first) begin
                id_reg <= pkt_id;
                byte_reg <= 2'h1;
                word_reg <= NAPC_WORD_RESET;
                shift_reg <= {pay_in.data, 16'h0000};
                byte_count_reg <= 9'h001;
            end else begin
                byte_reg <= byte_reg + 2'h1;
                shift_reg <= {pay_in.data, shift_reg[23:8]};
                byte_count_reg <= byte_count_reg + 9'h001;
                if (word_full) begin
                    word_reg <= word_reg + 3'h1;
                end
            end
        end
    end

    // stage words so a packet that ends short or long is never half written
    always_ff @(posedge core_clk) begin
        if (state_reg == ST_FIXED && word_full && word_reg < 3'(NAPC_MAX_WORDS)) begin
            stage_reg[word_reg] <= word_now;
        end
    end

    // commit only when the last byte lands exactly on the declared length
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            commit_reg <= 1'b0;
            commit_cnt_reg <= NAPC_WORD_RESET;
            commit_idx_reg <= NAPC_WORD_RESET;
            pkt_done <= 1'b0;
            pkt_reject <= 1'b0;
            done_id <= 8'h00;
        end else begin
            pkt_done <= 1'b0;
            pkt_reject <= 1'b0;
            if (pay_in.valid && pay_in.last && !pay_in.first) begin
                done_id <= id_reg;
                if (state_reg == ST_FIXED && byte_count_reg + 9'h001 == fixed_len(id_reg)) begin
                    commit_reg <= 1'b1;
                    commit_cnt_reg <= 3'(fixed_len(id_reg) >> 2);
                    commit_idx_reg <= NAPC_WORD_RESET;
                end else if (state_reg == ST_PASS && byte_count_reg < NAPC_LEN_CORR_MAX) begin
                    pkt_done <= 1'b1;
                end else begin
                    pkt_reject <= 1'b1;
                end
            end else if (pay_in.valid && pay_in.last) begin
                done_id <= pkt_id;
                // a one-byte packet only fits the pass-through type
                if (start_ok && kind_of(pkt_id) == NAPC_PKT_VARIABLE) begin
                    pkt_done <= 1'b1;
                end else begin
                    pkt_reject <= 1'b1;
                end
            end
            if (commit_reg) begin
                commit_idx_reg <= commit_idx_reg + 3'h1;
                if (commit_idx_reg + 3'h1 == commit_cnt_reg) begin
                    commit_reg <= 1'b0;
                    pkt_done <= 1'b1;
                end
            end
        end
    end

    assign wr_en = commit_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            field_out <= '0;
        end else begin
            field_out.valid <= commit_reg;
            field_out.id <= done_id;
            field_out.index <= commit_idx_reg;
            field_out.value <= stage_reg[commit_idx_reg];
        end
    end

    // correction bytes go through untouched, one cycle late
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            corr_out <= '0;
        end else begin
            corr_out.valid <= pay_in.valid && (state_next == ST_PASS
                || (state_reg == ST_PASS && pay_in.last)
                || (pay_in.first && pay_in.last && start_ok && kind_of(pkt_id) == NAPC_PKT_VARIABLE));
            corr_out.first <= pay_in.first;
            corr_out.last <= pay_in.last;
            corr_out.data <= pay_in.data;
        end
    end

    napc_store u_store (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_en(wr_en),
        .wr_addr(slot_of(done_id, commit_idx_reg)),
        .wr_data(stage_reg[commit_idx_reg]),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );
endmodule : napc_codec

// [rtl/napc_pkg.sv]
// napc_pkg: constants and carrier types for the aiding packet payload codec
// assumes one clock; payload bytes arrive one per cycle after the frame layer strips header and checksum
package napc_pkg;
    localparam logic [7:0] NAPC_ID_EXT_VEL = 8'h2E;
    localparam logic [7:0] NAPC_ID_BODY_VEL = 8'h2F;
    localparam logic [7:0] NAPC_ID_HEADING = 8'h30;
    localparam logic [7:0] NAPC_ID_RUN_TIME = 8'h31;
    localparam logic [7:0] NAPC_ID_MAG_FIELD = 8'h32;
    localparam logic [7:0] NAPC_ID_EXT_TIME = 8'h34;
    localparam logic [7:0] NAPC_ID_DEPTH = 8'h35;
    localparam logic [7:0] NAPC_ID_GEOID = 8'h36;
    localparam logic [7:0] NAPC_ID_CORR = 8'h37;
    localparam logic [7:0] NAPC_ID_HEAVE = 8'h3A;

    localparam logic [8:0] NAPC_LEN_EXT_VEL = 9'h018;
    localparam logic [8:0] NAPC_LEN_BODY_VEL = 9'h010;
    localparam logic [8:0] NAPC_LEN_HEADING = 9'h008;
    localparam logic [8:0] NAPC_LEN_RUN_TIME = 9'h008;
    localparam logic [8:0] NAPC_LEN_MAG_FIELD = 9'h00C;
    localparam logic [8:0] NAPC_LEN_EXT_TIME = 9'h008;
    localparam logic [8:0] NAPC_LEN_DEPTH = 9'h008;
    localparam logic [8:0] NAPC_LEN_GEOID = 9'h004;
    localparam logic [8:0] NAPC_LEN_CORR_MAX = 9'h0FF;
    localparam logic [8:0] NAPC_LEN_HEAVE = 9'h010;

    // largest fixed payload, in 32-bit words
    localparam int NAPC_MAX_WORDS = 6;
    localparam logic [2:0] NAPC_WORD_RESET = 3'h0;
    localparam logic [31:0] NAPC_VALUE_RESET = 32'h0000_0000;

    // one payload byte from the frame layer
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [7:0] data;
    } napc_byte_t;

    // one decoded 32-bit field written into the value store
    typedef struct packed {
        logic valid;
        logic [7:0] id;
        logic [2:0] index;
        logic [31:0] value;
    } napc_field_t;

    typedef enum logic [1:0] {
        NAPC_PKT_FIXED,
        NAPC_PKT_VARIABLE,
        NAPC_PKT_UNKNOWN
    } napc_kind_t;
endpackage : napc_pkg

// [rtl/napc_store.sv]
// napc_store: small value memory for decoded aiding fields, one word per slot
// assumes writes come from the codec; read data are registered
`timescale 1ns/1ps
module napc_store
    import napc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [6:0] rd_addr,
    output logic [31:0] rd_data
);
    logic [31:0] mem_reg [0:127];

    // contents are not reset; callers only read slots after a valid packet
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_data <= NAPC_VALUE_RESET;
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule : napc_store

// [verif/napc_codec_checker.sv]
// napc_codec_checker: port-level timing and acceptance properties of the codec
// assumes a bind onto napc_codec; tracks id, length and byte count on its own
`timescale 1ns/1ps
module napc_codec_checker
    import napc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] pkt_id,
    input wire logic [8:0] pkt_len,
    input wire napc_byte_t pay_in,
    input wire logic [6:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire napc_field_t field_out,
    input wire napc_byte_t corr_out,
    input wire logic pkt_done,
    input wire logic pkt_reject,
    input wire logic [7:0] done_id
);
    logic [7:0] id_reg, eid;
    logic [8:0] len_reg, cnt_reg, elen, ecnt, flen;
    logic ok_fix, ok_corr, bad_last;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge core_clk) begin
        if (pay_in.valid && pay_in.first) {id_reg, len_reg} <= {pkt_id, pkt_len};
    end
    always_ff @(posedge core_clk) begin
        cnt_reg <= !rst_n ? 9'h000 : pay_in.valid ? ecnt + 9'h001 : cnt_reg;
    end
    assign eid = pay_in.first ? pkt_id : id_reg;
    assign elen = pay_in.first ? pkt_len : len_reg;
    assign ecnt = pay_in.first ? 9'h000 : cnt_reg;
    always_comb begin
        case (eid)
            8'h2E: flen = 9'h018;
            8'h2F, 8'h3A: flen = 9'h010;
            8'h30, 8'h31, 8'h34, 8'h35: flen = 9'h008;
            8'h32: flen = 9'h00C;
            8'h36: flen = 9'h004;
            default: flen = 9'h000;
        endcase
    end
    assign ok_fix = pay_in.valid && pay_in.last && flen != 9'h000 && elen == flen && ecnt + 9'h001 == elen;
    assign ok_corr = pay_in.valid && eid == 8'h37 && elen <= 9'h0FF;
    // pass-through is only bounded by the maximum; its byte count is not held against the declared length
    assign bad_last = pay_in.valid && pay_in.last && !ok_fix && !(ok_corr && ecnt < 9'h0FF);
    sequence s_word(logic [2:0] i);
        field_out.valid && field_out.index == i && field_out.id == id_reg;
    endsequence
    a_corr_echo: assert property (ok_corr |=> corr_out.valid && corr_out.data == $past(pay_in.data))
        else $error("pass-through byte lost or altered");
    a_corr_finish: assert property (ok_corr && pay_in.last && ecnt < 9'h0FF |=> pkt_done)
        else $error("pass-through end not signalled");
    a_bad_reject: assert property (bad_last |=> pkt_reject && !pkt_done)
        else $error("bad packet not rejected");
    a_reject_quiet: assert property (bad_last |=> !field_out.valid [*8])
        else $error("rejected packet wrote a field");
    a_one_word: assert property (ok_fix && elen == 9'h004 |=> !field_out.valid ##1 s_word(0) ##0 pkt_done)
        else $error("single word commit wrong");
    a_two_words: assert property (ok_fix && elen == 9'h008 |=> !field_out.valid ##1 s_word(0) ##1 s_word(1) ##0 pkt_done)
        else $error("two word commit wrong");
    a_six_words: assert property (ok_fix && elen == 9'h018 |-> ##7 pkt_done && field_out.index == 3'h5)
        else $error("six word commit wrong");
    a_done_pulse: assert property (pkt_done |=> !pkt_done)
        else $error("done longer than one cycle");
endmodule : napc_codec_checker

bind napc_codec napc_codec_checker napc_codec_checker_i (.core_clk(core_clk), .rst_n(rst_n), .pkt_id(pkt_id),
    .pkt_len(pkt_len), .pay_in(pay_in), .rd_addr(rd_addr), .rd_data(rd_data), .field_out(field_out),
    .corr_out(corr_out), .pkt_done(pkt_done), .pkt_reject(pkt_reject), .done_id(done_id));

// [verif/napc_host.sv]
// napc_host: aiding sensor side, one payload byte per cycle
// assumes the bench leaves the idle gap between packets
`timescale 1ns/1ps
module napc_host
    import napc_pkg::*;
(
    input wire logic core_clk,
    output logic [7:0] pkt_id,
    output logic [8:0] pkt_len,
    output napc_byte_t pay_in
);
    initial {pkt_id, pkt_len, pay_in} = '0;
    // byte i is seed^i so each little-endian word can be predicted
    task automatic send(input logic [7:0] id, input logic [8:0] len, input int n, input logic [7:0] s);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            pkt_id = (i == 0) ? id : ~id;
            pkt_len = (i == 0) ? len : ~len;
            pay_in = '{1'b1, i == 0, i == n - 1, s ^ 8'(i)};
        end
        @(negedge core_clk);
        // idle lines show the inverse, never a stale copy
        pay_in = '{1'b0, 1'b0, 1'b0, ~pay_in.data};
        {pkt_id, pkt_len} = ~{pkt_id, pkt_len};
    endtask : send
endmodule : napc_host

// [verif/napc_codec_tb.sv]
// napc_codec_tb: self-checking bench for the aiding payload codec
// assumes napc_host feeds the payload and the checker is bound in
`timescale 1ns/1ps
module napc_codec_tb;
    import napc_pkg::*;
    logic core_clk, rst_n, pkt_done, pkt_reject;
    logic [7:0] pkt_id, done_id;
    logic [8:0] pkt_len;
    logic [6:0] rd_addr;
    logic [31:0] rd_data;
    napc_byte_t pay_in, corr_out;
    napc_field_t field_out;
    int n_errors = 0;
    int compares = 0;
    int n_done, n_rej;
    napc_field_t fq[$];
    napc_byte_t cq[$];
    napc_host napc_host_i (.core_clk(core_clk), .pkt_id(pkt_id), .pkt_len(pkt_len), .pay_in(pay_in));
    napc_codec napc_codec_i (.core_clk(core_clk), .rst_n(rst_n), .pkt_id(pkt_id), .pkt_len(pkt_len),
        .pay_in(pay_in), .rd_addr(rd_addr), .rd_data(rd_data), .field_out(field_out), .corr_out(corr_out),
        .pkt_done(pkt_done), .pkt_reject(pkt_reject), .done_id(done_id));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // sampled mid-cycle so one-cycle pulses are seen settled
    always @(negedge core_clk) begin
        if (field_out.valid === 1'b1) fq.push_back(field_out);
        if (corr_out.valid === 1'b1) cq.push_back(corr_out);
        if (pkt_done === 1'b1) n_done++;
        if (pkt_reject === 1'b1) n_rej++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [31:0] word(input logic [7:0] s, input int k);
        return {s ^ 8'(4 * k + 3), s ^ 8'(4 * k + 2), s ^ 8'(4 * k + 1), s ^ 8'(4 * k)};
    endfunction : word
    task automatic run(input logic [7:0] id, input logic [8:0] len, input int n, input logic [7:0] s);
        fq.delete();
        cq.delete();
        {n_done, n_rej} = '0;
        napc_host_i.send(id, len, n, s);
        repeat (10) @(negedge core_clk);
    endtask : run
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        rd_addr = a;
        @(negedge core_clk);
        d = rd_data;
    endtask : rd
    task automatic t_fixed(input logic [7:0] id, input logic [8:0] len, input logic [7:0] s);
        logic [31:0] d;
        run(id, len, int'(len), s);
        chk(32'(fq.size()), 32'(len / 4));
        chk(32'(n_done), 32'h1);
        chk(32'(done_id), 32'(id));
        foreach (fq[k]) begin
            chk(32'({fq[k].id, fq[k].index}), 32'({id, 3'(k)}));
            chk(fq[k].value, word(s, k));
            rd({id[3:0], 3'(k)}, d);
            chk(d, word(s, k));
        end
    endtask : t_fixed
    task automatic t_corr(input logic [8:0] len, input int n, input logic ok);
        run(8'h37, len, n, 8'hA5);
        chk(32'(cq.size()), ok ? 32'(n) : 32'h0);
        chk(32'(n_rej), ok ? 32'h0 : 32'h1);
        chk(32'(n_done), ok ? 32'h1 : 32'h0);
        foreach (cq[i]) begin
            chk(32'(cq[i].data), 32'(8'hA5 ^ 8'(i)));
            chk(32'({cq[i].first, cq[i].last}), 32'({i == 0, i == n - 1}));
        end
    endtask : t_corr
    task automatic t_reject(input logic [7:0] id, input logic [8:0] len, input int n);
        logic [31:0] d;
        run(id, len, n, 8'h5A);
        chk(32'(n_rej), 32'h1);
        chk(32'(fq.size() + n_done), 32'h0);
        rd(7'h00, d);
        chk(d, word(8'h30, 0));
    endtask : t_reject
    task automatic summarize();
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #(25 * 4000);
        n_errors++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        rd_addr = 7'h00;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        t_fixed(8'h2E, 9'h018, 8'h10);
        t_fixed(8'h2F, 9'h010, 8'h21);
        t_fixed(8'h30, 9'h008, 8'h30);
        t_fixed(8'h31, 9'h008, 8'h43);
        t_fixed(8'h32, 9'h00C, 8'h54);
        t_fixed(8'h34, 9'h008, 8'h65);
        t_fixed(8'h35, 9'h008, 8'h76);
        t_fixed(8'h36, 9'h004, 8'h87);
        t_fixed(8'h3A, 9'h010, 8'h98);
        t_corr(9'h003, 3, 1'b1);
        t_corr(9'h001, 1, 1'b1);
        t_corr(9'h0FF, 255, 1'b1);
        t_corr(9'h100, 4, 1'b0);
        t_reject(8'h30, 9'h00C, 12);
        t_reject(8'h30, 9'h008, 7);
        t_reject(8'h30, 9'h008, 9);
        t_reject(8'h33, 9'h008, 8);
        t_reject(8'h36, 9'h004, 1);
        summarize();
    end
endmodule : napc_codec_tb
